// ==== hw/psb_burst_seq.sv ====
`timescale 1ns/100ps
module psb_burst_seq
   import psb_pkg::*;
#(
   parameter int PU_CYCLES      = PU_CYC,
   parameter int DPD_MIN_CYCLES = DPD_CYC
) (
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               reset_n,
   // memory bus pins
   input  wire logic               burst_clk,
   input  wire logic               select_n,
   input  wire logic               address_valid_n,
   input  wire logic               write_en_n,
   input  wire logic               output_en_n,
   input  wire logic [UPPER_W-1:0] upper_addr,
   input  wire logic [DATA_W-1:0]  adq_in,
   output logic [DATA_W-1:0]       adq_out,
   output logic                    adq_oe,
   output logic                    wait_out,
   output logic                    wait_oe,
   // burst configuration
   input  wire logic [LAT_W-1:0]   latency_count_code,
   input  wire logic               fixed_latency,
   input  wire logic               wait_active_high,
   input  wire logic               wait_one_early,
   input  wire logic               sync_mode,
   input  wire logic [2:0]         burst_len_sel,
   input  wire logic               burst_wrap,
   input  wire logic               deep_power_down,
   // array write stream
   output logic                    arr_wr_valid,
   input  wire logic               arr_wr_ready,
   output logic [ADDR_W-1:0]       arr_wr_addr,
   output logic [DATA_W-1:0]       arr_wr_data,
   // array read port
   output logic [ADDR_W-1:0]       arr_rd_addr,
   input  wire logic [DATA_W-1:0]  arr_rd_data,
   // status
   output logic                    init_done,
   output logic                    refresh_opportunity,
   output logic                    select_low_overrun,
   output logic                    dpd_too_short
);
   // ==========================================================
   // helpers
   function automatic logic [LEN_W-1:0] burst_words(input logic [2:0] s);
      case (s)
         BL_4:    return LEN_W'(4);
         BL_8:    return LEN_W'(8);
         BL_16:   return LEN_W'(16);
         BL_32:   return LEN_W'(32);
         default: return '0;
      endcase
   endfunction

   function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
      input logic [LEN_W-1:0] len, input logic wrap);
      logic [ADDR_W-1:0] m;
      m = ADDR_W'(len) - ADDR_W'(1);
      if (wrap && len != '0)
         return (a & ~m) | ((a + ADDR_W'(1)) & m);
      return a + ADDR_W'(1);
   endfunction

   // wrapped bursts stay inside their aligned block and never meet a row end
   function automatic logic row_end(input logic [ADDR_W-1:0] a,
      input logic [LEN_W-1:0] len, input logic wrap);
      return (a[ROW_BITS-1:0] == '1) && !(wrap && len != '0);
   endfunction

   // ==========================================================
   // pin sampling
   logic [PIN_W-1:0]   pins_s;
   logic               s_clk, s_sel_n, s_av_n, s_we_n, s_oe_n;
   logic [UPPER_W-1:0] s_upper;
   logic [DATA_W-1:0]  s_adq;
   logic               clk_prev_q, av_prev_q, we_prev_q;
   logic               clk_rise, av_fall, av_rise, we_rise;

   psb_pin_sync #(.W(PIN_W)) u_sync (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .pin_i    ({burst_clk, select_n, address_valid_n, write_en_n, output_en_n,
                  upper_addr, adq_in}),
      .stable_q (pins_s)
   );

   assign {s_clk, s_sel_n, s_av_n, s_we_n, s_oe_n, s_upper, s_adq} = pins_s;
   assign clk_rise = s_clk && !clk_prev_q;
   assign av_fall  = !s_av_n && av_prev_q;
   assign av_rise  = s_av_n && !av_prev_q;
   assign we_rise  = s_we_n && !we_prev_q;

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         clk_prev_q <= 1'b1; // synchroniser resets high, so no false edge
         av_prev_q  <= 1'b1;
         we_prev_q  <= 1'b1;
      end
      else
      begin
         clk_prev_q <= s_clk;
         av_prev_q  <= s_av_n;
         we_prev_q  <= s_we_n;
      end
   end

   // ==========================================================
   // power-up and deep power-down
   psb_pwr_t         pwr_q;
   logic [CNT_W-1:0] pwr_cnt_q;

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         pwr_q         <= PW_INIT;
         pwr_cnt_q     <= '0;
         dpd_too_short <= 1'b0;
      end
      else
         case (pwr_q)
            PW_INIT:
               if (pwr_cnt_q >= CNT_W'(PU_CYCLES - 1))
               begin
                  pwr_q     <= PW_READY;
                  pwr_cnt_q <= '0;
               end
               else
                  pwr_cnt_q <= pwr_cnt_q + CNT_W'(1);
            PW_READY:
               if (deep_power_down)
               begin
                  pwr_q     <= PW_DPD;
                  pwr_cnt_q <= '0;
               end
            PW_DPD:
               if (!deep_power_down)
               begin
                  dpd_too_short <= (pwr_cnt_q < CNT_W'(DPD_MIN_CYCLES));
                  pwr_q         <= PW_EXIT;
                  pwr_cnt_q     <= '0;
               end
               else if (pwr_cnt_q != '1)
                  pwr_cnt_q <= pwr_cnt_q + CNT_W'(1);
            PW_EXIT:
               if (pwr_cnt_q >= CNT_W'(DPDX_CYC - 1))
               begin
                  pwr_q     <= PW_READY;
                  pwr_cnt_q <= '0;
               end
               else
                  pwr_cnt_q <= pwr_cnt_q + CNT_W'(1);
            default:
               pwr_q <= PW_INIT;
         endcase
   end

   assign init_done = (pwr_q == PW_READY);

   // ==========================================================
   // access sequencer
   psb_state_t        st_q;
   logic [ADDR_W-1:0] addr_q;
   logic [3:0]        cnt_q;
   logic [LEN_W-1:0]  words_q;
   logic              is_wr_q, fresh_q, load_q, burst_fixed_q;
   logic [LEN_W-1:0]  len;
   logic              fifo_ready, push, stall, start_ok, can_start;
   logic              at_len_rd, at_len_wr;

   assign len        = burst_words(burst_len_sel);
   assign at_len_rd  = (len != '0) && (words_q == len);
   assign at_len_wr  = (len != '0) && (words_q + LEN_W'(1) == len);
   assign stall      = is_wr_q && (st_q == ST_DATA) && !fifo_ready;
   assign push       = is_wr_q && (st_q == ST_DATA) && clk_rise && fifo_ready && !s_sel_n;
   // a fresh select may start anything; otherwise only a fixed-latency read
   assign start_ok   = fresh_q || (fixed_latency && s_we_n);
   assign can_start  = init_done && sync_mode && clk_rise && !s_av_n && start_ok;

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n || !init_done || s_sel_n)
      begin
         st_q    <= ST_IDLE;
         fresh_q <= 1'b1;
         load_q  <= 1'b0;
         cnt_q   <= '0;
         words_q <= '0;
         is_wr_q <= 1'b0;
         burst_fixed_q <= 1'b0;
      end
      else
      begin
         load_q <= 1'b0;
         if (can_start && (st_q == ST_IDLE || st_q == ST_ASYNC))
         begin
            is_wr_q       <= !s_we_n;
            burst_fixed_q <= fixed_latency;
            fresh_q       <= 1'b0;
            words_q       <= '0;
            if (!s_we_n)
            begin
               cnt_q <= 4'(latency_count_code);
               st_q  <= (latency_count_code == '0) ? ST_DATA : ST_LAT;
            end
            else
            begin
               cnt_q <= 4'(latency_count_code) + 4'h1;
               st_q  <= ST_LAT;
            end
         end
         else
            case (st_q)
               ST_IDLE:
                  if (av_fall)
                     st_q <= ST_ASYNC;
               ST_ASYNC:
               begin
                  if (av_rise || we_rise)
                     fresh_q <= 1'b0;
                  if (av_rise)
                     load_q <= 1'b1;
               end
               ST_LAT:
                  if (clk_rise)
                  begin
                     cnt_q <= cnt_q - 4'h1;
                     if (cnt_q == 4'h1)
                     begin
                        st_q <= ST_DATA;
                        if (!is_wr_q)
                        begin
                           load_q  <= 1'b1;
                           words_q <= LEN_W'(1);
                        end
                     end
                  end
               ST_DATA:
                  if (clk_rise && !stall)
                  begin
                     if (!is_wr_q && at_len_rd)
                        st_q <= ST_END;
                     else if (is_wr_q && at_len_wr)
                     begin
                        st_q    <= ST_END;
                        words_q <= words_q + LEN_W'(1);
                     end
                     else if (row_end(addr_q, len, burst_wrap)
                              && latency_count_code != '0)
                     begin
                        st_q  <= ST_ROWWAIT;
                        cnt_q <= 4'(latency_count_code);
                        if (is_wr_q)
                           words_q <= words_q + LEN_W'(1);
                     end
                     else
                     begin
                        words_q <= words_q + LEN_W'(1);
                        load_q  <= !is_wr_q;
                     end
                  end
               ST_ROWWAIT:
                  if (clk_rise)
                  begin
                     cnt_q <= cnt_q - 4'h1;
                     if (cnt_q == 4'h1)
                     begin
                        st_q <= ST_DATA;
                        if (!is_wr_q)
                        begin
                           load_q  <= 1'b1;
                           words_q <= words_q + LEN_W'(1);
                        end
                     end
                  end
               ST_END:
                  ;
               default:
                  st_q <= ST_IDLE;
            endcase
         // a fixed-latency read hands over to async at address-valid fall
         if (av_fall && !is_wr_q && burst_fixed_q
             && (st_q == ST_DATA || st_q == ST_END || st_q == ST_ROWWAIT))
            st_q <= ST_ASYNC;
      end
   end

   // address tracking
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         addr_q <= '0;
      else if (can_start && (st_q == ST_IDLE || st_q == ST_ASYNC))
         addr_q <= {s_upper, s_adq};
      else if (st_q == ST_ASYNC && av_rise)
         addr_q <= {s_upper, s_adq};
      else if (st_q == ST_DATA && clk_rise && !stall && !s_sel_n)
      begin
         if (is_wr_q || !at_len_rd)
            addr_q <= next_addr(addr_q, len, burst_wrap);
      end
   end

   assign arr_rd_addr = addr_q;

   // ==========================================================
   // write buffer toward the array
   logic fifo_push;
   assign fifo_push = push || (st_q == ST_ASYNC && we_rise && !s_sel_n);

   psb_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .in_valid  (fifo_push),
      .in_ready  (fifo_ready),
      .in_data   ({addr_q, s_adq}),
      .out_valid (arr_wr_valid),
      .out_ready (arr_wr_ready),
      .out_data  ({arr_wr_addr, arr_wr_data})
   );

   // ==========================================================
   // data and wait drivers
   logic rd_phase, wait_now, wait_early, wait_act;

   assign rd_phase = !is_wr_q && (st_q == ST_DATA || st_q == ST_ROWWAIT);
   // in a sync burst write, a full buffer holds the controller off with WAIT
   assign wait_now = (st_q == ST_LAT) || (st_q == ST_ROWWAIT) || stall;
   assign wait_early = ((st_q == ST_LAT || st_q == ST_ROWWAIT) && cnt_q > 4'h1) || stall
                       || (st_q == ST_DATA && latency_count_code != '0
                           && row_end(addr_q, len, burst_wrap)
                           && !(is_wr_q ? at_len_wr : at_len_rd));
   assign wait_act = wait_one_early ? wait_early : wait_now;

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         adq_out  <= '0;
         adq_oe   <= 1'b0;
         wait_out <= 1'b0;
         wait_oe  <= 1'b0;
      end
      else
      begin
         if (load_q)
            adq_out <= arr_rd_data;
         else if (st_q == ST_END && !is_wr_q)
            adq_out <= '0;
         adq_oe   <= !s_sel_n && !s_oe_n
                     && (rd_phase || (st_q == ST_END && !is_wr_q)
                         || (st_q == ST_ASYNC && s_we_n));
         wait_out <= (!s_sel_n && wait_act) == wait_active_high;
         wait_oe  <= !s_sel_n && init_done;
      end
   end

   // ==========================================================
   // refresh opportunities and select-low watchdog
   logic [CNT_W-1:0] hi_cnt_q, lo_cnt_q;
   logic             given_q, opp;

   // clocked select high, or high for longer than the gap
   assign opp = s_sel_n && !given_q
                && (clk_rise || hi_cnt_q >= CNT_W'(REF_GAP_CYC));

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         hi_cnt_q            <= '0;
         given_q             <= 1'b0;
         refresh_opportunity <= 1'b0;
      end
      else
      begin
         refresh_opportunity <= opp;
         if (!s_sel_n)
         begin
            hi_cnt_q <= '0;
            given_q  <= 1'b0;
         end
         else
         begin
            if (hi_cnt_q != '1)
               hi_cnt_q <= hi_cnt_q + CNT_W'(1);
            if (opp)
               given_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         lo_cnt_q           <= '0;
         select_low_overrun <= 1'b0;
      end
      else if (opp)
      begin
         lo_cnt_q           <= '0;
         select_low_overrun <= 1'b0;
      end
      else if (!s_sel_n)
      begin
         if (lo_cnt_q != '1)
            lo_cnt_q <= lo_cnt_q + CNT_W'(1);
         if (lo_cnt_q >= CNT_W'(CEM_CYC))
            select_low_overrun <= 1'b1;
      end
   end
endmodule

// ==== hw/psb_pkg.sv ====
package psb_pkg;
   // ==========================================================
   // widths
   localparam int ADDR_W    = 22;
   localparam int DATA_W    = 16;
   localparam int UPPER_W   = 6;
   localparam int LAT_W     = 3;
   localparam int ROW_BITS  = 7;
   localparam int CNT_W     = 16;
   localparam int LEN_W     = 6;
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_W    = ADDR_W + DATA_W;
   localparam int PIN_W     = 5 + UPPER_W + DATA_W;
   // ==========================================================
   // timing
   localparam int CLK_MHZ       = 50;
   localparam int T_PU_US       = 150;
   localparam int T_DPD_US      = 150;
   localparam int T_DPDX_US     = 10;
   localparam int T_CEM_US      = 4;
   localparam int T_REF_GAP_NS  = 15;
   localparam int PU_CYC        = T_PU_US * CLK_MHZ;
   localparam int DPD_CYC       = T_DPD_US * CLK_MHZ;
   localparam int DPDX_CYC      = T_DPDX_US * CLK_MHZ;
   localparam int CEM_CYC       = T_CEM_US * CLK_MHZ;
   localparam int REF_GAP_CYC   = (T_REF_GAP_NS * CLK_MHZ + 999) / 1000;
   // ==========================================================
   // burst length select codes
   localparam logic [2:0] BL_4  = 3'h1;
   localparam logic [2:0] BL_8  = 3'h2;
   localparam logic [2:0] BL_16 = 3'h3;
   localparam logic [2:0] BL_32 = 3'h4;
   // ==========================================================
   // types
   typedef enum logic [2:0] {
      ST_IDLE, ST_ASYNC, ST_LAT, ST_DATA, ST_ROWWAIT, ST_END
   } psb_state_t;
   typedef enum logic [1:0] {
      PW_INIT, PW_READY, PW_DPD, PW_EXIT
   } psb_pwr_t;
endpackage

// ==== hw/psb_pin_sync.sv ====
`timescale 1ns/100ps
module psb_pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         reset_n,
   // pins
   input  wire logic [W-1:0] pin_i,
   output logic [W-1:0]      stable_q
);
   logic [W-1:0] ff1_q;
   logic [W-1:0] ff2_q;
   logic [W-1:0] ff3_q;

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         ff1_q <= '1;
         ff2_q <= '1;
         ff3_q <= '1;
      end
      else
      begin
         ff1_q <= pin_i;
         ff2_q <= ff1_q;
         ff3_q <= ff2_q;
      end
   end

   // a bit moves only once stages two and three agree
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         stable_q <= '1;
      else
         for (int i = 0; i < W; i++)
            if (ff2_q[i] == ff3_q[i])
               stable_q[i] <= ff3_q[i];
   end
endmodule

// ==== hw/psb_fifo.sv ====
`timescale 1ns/100ps
module psb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;

   assign in_ready  = (count_q != (AW+1)'(DEPTH));
   assign out_valid = (count_q != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_q];

   always_ff @(posedge sys_clk)
   begin
      if (push)
         mem[wr_q] <= in_data;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         wr_q    <= '0;
         rd_q    <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
         if (pop)
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
         if (push && !pop)
            count_q <= count_q + (AW+1)'(1);
         else if (pop && !push)
            count_q <= count_q - (AW+1)'(1);
      end
   end
endmodule

// ==== verification/psb_burst_seq_monitor.sv ====
`timescale 1ns/100ps
module psb_burst_seq_monitor
   import psb_pkg::*;
#(
   parameter int PU_CYCLES = 50
) (
   // clock and reset
   input wire logic              sys_clk,
   input wire logic              reset_n,
   // watched pins
   input wire logic              select_n,
   input wire logic              deep_power_down,
   input wire logic              adq_oe,
   input wire logic              wait_oe,
   input wire logic              arr_wr_valid,
   input wire logic              arr_wr_ready,
   input wire logic [ADDR_W-1:0] arr_wr_addr,
   input wire logic [DATA_W-1:0] arr_wr_data,
   input wire logic              init_done,
   input wire logic              refresh_opportunity,
   input wire logic              select_low_overrun
);
   // ====================
   // helper counters
   int   up_q;
   int   low_q;
   logic first_q;
   always_ff @(posedge sys_clk)
      if (!reset_n) up_q <= 0;
      else if (!init_done) up_q <= up_q + 1;
   always_ff @(posedge sys_clk)
      if (!reset_n) first_q <= 1'b0;
      else if (init_done) first_q <= 1'b1;
   // low run restarts on any opportunity, as the device's own count does
   always_ff @(posedge sys_clk)
      if (!reset_n || select_n || refresh_opportunity) low_q <= 0;
      else low_q <= low_q + 1;
   // ====================
   // properties
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   init_time_a: assert property (
      $rose(init_done) && !first_q |-> up_q inside {[PU_CYCLES-1:PU_CYCLES+2]})
      else $error("init_done rose at the wrong time");
   dpd_hold_a: assert property (deep_power_down [*8] |-> !init_done)
      else $error("ready during deep power-down");
   init_gate_a: assert property (!init_done |-> !adq_oe && !wait_oe)
      else $error("bus driven before ready");
   idle_release_a: assert property (select_n [*8] |-> !wait_oe && !adq_oe)
      else $error("bus driven while deselected");
   wait_gate_a: assert property (wait_oe |-> $past(init_done))
      else $error("wait driven while not ready");
   stream_hold_a: assert property (
      arr_wr_valid && !arr_wr_ready |=> arr_wr_valid && $stable(arr_wr_addr)
      && $stable(arr_wr_data)) else $error("array write changed while stalled");
   ref_pulse_a: assert property (refresh_opportunity |=> !refresh_opportunity)
      else $error("refresh pulse too long");
   ref_clear_a: assert property (refresh_opportunity |=> !select_low_overrun)
      else $error("overrun not cleared");
   overrun_time_a: assert property (
      $rose(select_low_overrun) |-> low_q inside {[198:210]})
      else $error("overrun flagged at the wrong time");
endmodule

// ==== verification/psb_host_model.sv ====
`timescale 1ns/100ps
module psb_host_model
   import psb_pkg::*;
(
   // clock and device answers
   input wire logic               sys_clk,
   input wire logic [DATA_W-1:0]  adq_out,
   input wire logic               wait_out,
   input wire logic               wait_oe,
   input wire logic               wait_active_high,
   // bus drive
   output logic                   burst_clk,
   output logic                   select_n,
   output logic                   address_valid_n,
   output logic                   write_en_n,
   output logic                   output_en_n,
   output logic [UPPER_W-1:0]     upper_addr,
   output logic [DATA_W-1:0]      adq_in
);
   int                waits;
   logic              w;
   logic [DATA_W-1:0] rq[$];
   initial
   begin
      {burst_clk, select_n, address_valid_n, write_en_n, output_en_n} = 5'h0F;
      {upper_addr, adq_in} = '0;
   end
   // ====================
   // one link clock; wait and data are sampled just before the next rise
   task automatic tick();
      burst_clk = 1'b1;
      repeat (4) @(negedge sys_clk);
      burst_clk = 1'b0;
      repeat (4) @(negedge sys_clk);
      w = wait_oe && (wait_out == wait_active_high);
   endtask
   task automatic start(input logic [ADDR_W-1:0] a, input logic wr);
      @(negedge sys_clk);
      {select_n, address_valid_n, write_en_n} = {2'h0, !wr};
      {upper_addr, adq_in} = a;
      repeat (2) @(negedge sys_clk);
      tick();
      address_valid_n = 1'b1;
      adq_in = ~adq_in;
      output_en_n = wr;
      waits = 0;
   endtask
   // clock stays still after the frame, so no edge follows the last word
   task automatic stop();
      {select_n, write_en_n, output_en_n} = 3'h7;
      adq_in = ~adq_in;
      repeat (4) @(negedge sys_clk);
   endtask
   // ====================
   // transfers
   task automatic rd(input logic [ADDR_W-1:0] a, input int n, input int x);
      int got = 0;
      rq = {};
      start(a, 1'b0);
      for (int i = 0; i < 64 && got < n + x; i++)
      begin
         if (i > 0) tick();
         if (w) waits++;
         else
         begin
            if (got < n) rq.push_back(adq_out);
            got++;
         end
      end
      stop();
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, input int n);
      int k = 0;
      start(a, 1'b1);
      for (int i = 0; i < 64 && k < n; i++)
      begin
         if (w) waits++;
         else
         begin
            adq_in = d0 + DATA_W'(k);
            k++;
         end
         tick();
      end
      stop();
   endtask
   task automatic aw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge sys_clk);
      {select_n, address_valid_n} = 2'h0;
      {upper_addr, adq_in} = a;
      repeat (3) @(negedge sys_clk);
      {address_valid_n, write_en_n} = 2'h2;
      // address holds a cycle past the address-valid rise
      @(negedge sys_clk);
      adq_in = d;
      repeat (3) @(negedge sys_clk);
      write_en_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      stop();
   endtask
   task automatic hold(input int n);
      @(negedge sys_clk);
      select_n = 1'b0;
      repeat (n) @(negedge sys_clk);
   endtask
endmodule

// ==== verification/psb_burst_sequencing_test.sv ====
`timescale 1ns/100ps
module psb_burst_sequencing_test;
   import psb_pkg::*;
   localparam int PU = 50;
   // ====================
   // signals
   logic                        sys_clk, reset_n, burst_clk, select_n, address_valid_n;
   logic                        write_en_n, output_en_n, adq_oe, wait_out, wait_oe;
   logic                        fixed_latency, wait_active_high, wait_one_early, sync_mode;
   logic                        burst_wrap, deep_power_down, arr_wr_valid, arr_wr_ready;
   logic                        init_done, refresh_opportunity, select_low_overrun;
   logic                        dpd_too_short;
   logic [UPPER_W-1:0]          upper_addr;
   logic [DATA_W-1:0]           adq_in, adq_out, arr_wr_data, arr_rd_data;
   logic [LAT_W-1:0]            latency_count_code;
   logic [2:0]                  burst_len_sel;
   logic [ADDR_W-1:0]           arr_wr_addr, arr_rd_addr;
   logic [ADDR_W+DATA_W-1:0]    sq[$];
   int                          n_fail = 0;
   int                          n_tests = 0;
   assign arr_rd_data = arr_rd_addr[15:0] ^ 16'h5A3C;
   psb_burst_seq #(.PU_CYCLES(PU), .DPD_MIN_CYCLES(PU)) DUT (.*);
   psb_host_model host (.*);
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
      if (arr_wr_valid && arr_wr_ready) sq.push_back({arr_wr_addr, arr_wr_data});
   // ====================
   // helpers
   task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string m);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t %s: got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic settle(input int n);
      for (int i = 0; i < n && init_done !== 1'b1; i++) @(negedge sys_clk);
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      wrap_up();
   end
   // ====================
   // tests
   initial
   begin
      {reset_n, fixed_latency, wait_active_high, wait_one_early} = 4'h0;
      {sync_mode, burst_wrap, deep_power_down, arr_wr_ready} = 4'hD;
      {latency_count_code, burst_len_sel} = {3'h2, BL_4};
      repeat (5) @(negedge sys_clk);
      reset_n = 1'b1;
      settle(300);
      chk(init_done, 1'b1, "power-up");
      $display("test power-up done");
      for (int c = 1; c <= 4; c++)
      begin
         latency_count_code = LAT_W'(c);
         {fixed_latency, wait_active_high} = {c[1], c[0]};
         host.rd(22'h000010, 4, 2);
         chk(host.waits, c + 1, "read latency");
         for (int k = 0; k < 4; k++)
            chk(host.rq[k], (16'h0010 + k) ^ 16'h5A3C, "read word");
      end
      $display("test burst read done");
      for (int c = 2; c <= 3; c++)
      begin
         {latency_count_code, fixed_latency} = {LAT_W'(c), c[0]};
         sq = {};
         host.wr(22'h000020, 16'hC000, 4);
         chk(host.waits, c, "write wait");
         repeat (12) @(negedge sys_clk);
         for (int k = 0; k < 4; k++)
            chk(sq[k], {ADDR_W'(22'h20 + k), DATA_W'(16'hC000 + k)}, "write push");
      end
      $display("test burst write done");
      {latency_count_code, burst_len_sel} = 6'h18;
      host.rd(22'h00007E, 4, 0);
      chk(host.waits, 7, "row crossing wait");
      chk(host.rq[2], 16'h0080 ^ 16'h5A3C, "row crossing word");
      $display("test row crossing done");
      sq = {};
      arr_wr_ready = 1'b0;
      host.aw(22'h012345, 16'hBEEF);
      repeat (6) @(negedge sys_clk);
      arr_wr_ready = 1'b1;
      repeat (6) @(negedge sys_clk);
      chk(sq[0], {22'h012345, 16'hBEEF}, "async write");
      $display("test async write done");
      host.hold(230);
      chk(select_low_overrun, 1'b1, "overrun set");
      host.stop();
      repeat (4) @(negedge sys_clk);
      chk(select_low_overrun, 1'b0, "overrun clear");
      $display("test overrun done");
      for (int s = 0; s < 2; s++)
      begin
         deep_power_down = 1'b1;
         repeat (s ? 60 : 20) @(negedge sys_clk);
         deep_power_down = 1'b0;
         repeat (8) @(negedge sys_clk);
         chk(dpd_too_short, !s, "power-down length");
         chk(init_done, 1'b0, "exit wait");
         settle(700);
         chk(init_done, 1'b1, "exit ready");
      end
      $display("test power-down done");
      wrap_up();
   end
endmodule

bind psb_burst_seq psb_burst_seq_monitor #(.PU_CYCLES(PU_CYCLES)) mon (.*);
